//--- hdl/asf_flag_unit.sv
/*
   alu result and status flag unit of an 8-bit core.
   assumes decoded op, operands and destination arrive on clk;
   ext_isa_pin is a configuration level from outside the domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "asf_params.svh"

module asf_flag_unit #(
   parameter int DATA_W = 8
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 op_valid,
   input  wire asf_pkg::asf_op_t     op_code,
   input  wire logic [DATA_W-1:0]    opnd_w,
   input  wire logic [DATA_W-1:0]    opnd_f,
   input  wire logic [2:0]           bit_sel,
   input  wire logic                 src_is_flags,
   input  wire logic                 dest_is_flags,
   input  wire logic                 ext_isa_pin,
   input  wire logic                 idx_req,
   output logic [DATA_W-1:0]         result_ff,
   output logic                      result_we_ff,
   output logic [DATA_W-1:0]         alu_flags_ff,
   output logic                      ext_isa_enable_ff,
   output logic                      idx_grant_ff
);

   // =====================================================
   // helpers
   // =====================================================
   // sum with split nibble carries: {carry, half carry, sum}
   function automatic logic [9:0] add8(
      input logic [7:0] a,
      input logic [7:0] b,
      input logic       ci
   );
      logic [4:0] lo;
      logic [4:0] hi;
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
      add8 = {hi[4], lo[4], hi[3:0], lo[3:0]};
   endfunction

   // signed overflow: like signs in, other sign out
   function automatic logic ovf(
      input logic [7:0] a,
      input logic [7:0] b,
      input logic [7:0] s
   );
      ovf = (a[7] == b[7]) && (s[7] != a[7]);
   endfunction

   // which of the five flags an op writes
   function automatic logic [4:0] flag_mask(
      input asf_pkg::asf_op_t op
   );
      flag_mask = 5'h00;
      unique case (op)
         asf_pkg::asf_op_add,
         asf_pkg::asf_op_addc,
         asf_pkg::asf_op_sub,
         asf_pkg::asf_op_subb,
         asf_pkg::asf_op_inc,
         asf_pkg::asf_op_dec,
         asf_pkg::asf_op_neg: begin
            flag_mask = 5'h1f;
         end
         asf_pkg::asf_op_and,
         asf_pkg::asf_op_ior,
         asf_pkg::asf_op_xor,
         asf_pkg::asf_op_com: begin
            flag_mask = 5'h14;
         end
         asf_pkg::asf_op_clr: begin
            flag_mask = 5'h04;
         end
         asf_pkg::asf_op_rlc,
         asf_pkg::asf_op_rrc: begin
            flag_mask = 5'h17;
         end
         asf_pkg::asf_op_mov,
         asf_pkg::asf_op_swap,
         asf_pkg::asf_op_bset,
         asf_pkg::asf_op_bclr: begin
            flag_mask = 5'h00;
         end
      endcase
   endfunction

   // rotate through carry: {half carry, carry} from the source byte
   // left takes bits 3 and 7, right bits 4 and 0
   function automatic logic [1:0] rot_flags(
      input logic [7:0] s,
      input logic       left
   );
      rot_flags = left ? {s[3], s[7]}
                       : {s[4], s[0]};
   endfunction

   // =====================================================
   // configuration bit synchroniser
   // =====================================================
   logic ext_meta_ff;
   logic ext_sync_ff;
   logic nxt_ext_meta;
   logic nxt_ext_sync;
   logic nxt_ext_isa_enable;
   logic nxt_idx_grant;

   // three flops before any logic reads the pin
   always_comb begin
      nxt_ext_meta       = ext_isa_pin;
      nxt_ext_sync       = ext_meta_ff;
      nxt_ext_isa_enable = ext_sync_ff;
      nxt_idx_grant      = idx_req && ext_isa_enable_ff;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_meta_ff       <= `ASF_EXT_RST;
         ext_sync_ff       <= `ASF_EXT_RST;
         ext_isa_enable_ff <= `ASF_EXT_RST;
         idx_grant_ff      <= `ASF_GRANT_RST;
      end else begin
         ext_meta_ff       <= nxt_ext_meta;
         ext_sync_ff       <= nxt_ext_sync;
         ext_isa_enable_ff <= nxt_ext_isa_enable;
         idx_grant_ff      <= nxt_idx_grant;
      end
   end

   // =====================================================
   // operand selection
   // =====================================================
   logic [7:0] src_f;
   logic [7:0] bit_one;

   always_comb begin
      src_f   = src_is_flags ? alu_flags_ff : opnd_f;
      bit_one = 8'h01 << bit_sel;
   end

   // =====================================================
   // alu core
   // =====================================================
   logic [7:0] calc;
   logic [4:0] calc_flags;
   logic [9:0] sum;
   logic [7:0] add_a;
   logic [7:0] add_b;
   logic       add_ci;
   logic       is_add;
   logic       cur_c;

   always_comb begin
      cur_c  = alu_flags_ff[`ASF_BIT_C];
      is_add = 1'b1;
      add_a  = src_f;
      add_b  = opnd_w;
      add_ci = 1'b0;
      unique case (op_code)
         asf_pkg::asf_op_add: begin
            add_ci = 1'b0;
         end
         asf_pkg::asf_op_addc: begin
            add_ci = cur_c;
         end
         asf_pkg::asf_op_sub: begin
            add_b  = ~opnd_w;
            add_ci = 1'b1;
         end
         asf_pkg::asf_op_subb: begin
            add_b  = ~opnd_w;
            add_ci = cur_c;
         end
         asf_pkg::asf_op_inc: begin
            add_b  = 8'h00;
            add_ci = 1'b1;
         end
         asf_pkg::asf_op_dec: begin
            add_b  = 8'hff;
         end
         asf_pkg::asf_op_neg: begin
            add_a  = 8'h00;
            add_b  = ~src_f;
            add_ci = 1'b1;
         end
         default: begin
            is_add = 1'b0;
         end
      endcase
      sum = add8(add_a, add_b, add_ci);
   end

   always_comb begin
      calc       = sum[7:0];
      calc_flags = 5'h00;
      if (is_add) begin
         calc_flags[`ASF_BIT_C]  = sum[9];
         calc_flags[`ASF_BIT_HC]  = sum[8];
         calc_flags[`ASF_BIT_SRF] = ovf(add_a, add_b, sum[7:0]);
      end else begin
         unique case (op_code)
            asf_pkg::asf_op_and: begin
               calc = src_f & opnd_w;
            end
            asf_pkg::asf_op_ior: begin
               calc = src_f | opnd_w;
            end
            asf_pkg::asf_op_xor: begin
               calc = src_f ^ opnd_w;
            end
            asf_pkg::asf_op_com: begin
               calc = ~src_f;
            end
            asf_pkg::asf_op_clr: begin
               calc = 8'h00;
            end
            asf_pkg::asf_op_rlc: begin
               calc = {src_f[6:0], cur_c};
               {calc_flags[`ASF_BIT_HC], calc_flags[`ASF_BIT_C]} = rot_flags(src_f, 1'b1);
            end
            asf_pkg::asf_op_rrc: begin
               calc = {cur_c, src_f[7:1]};
               {calc_flags[`ASF_BIT_HC], calc_flags[`ASF_BIT_C]} = rot_flags(src_f, 1'b0);
            end
            asf_pkg::asf_op_mov: begin
               calc = opnd_w;
            end
            asf_pkg::asf_op_swap: begin
               calc = {src_f[3:0], src_f[7:4]};
            end
            asf_pkg::asf_op_bset: begin
               calc = src_f | bit_one;
            end
            asf_pkg::asf_op_bclr: begin
               calc = src_f & ~bit_one;
            end
            default: begin
               calc = sum[7:0];
            end
         endcase
      end
      calc_flags[`ASF_BIT_N] = calc[7];
      calc_flags[`ASF_BIT_Z] = (calc == 8'h00);
   end

   // =====================================================
   // flag write decode
   // =====================================================
   logic      [`ASF_FLAG_W-1:0] mask;
   wire logic [`ASF_FLAG_W-1:0] merged;

   // which flags the op may write
   always_comb begin
      mask = flag_mask(op_code);
   end

   // masked flags take the alu value, the rest hold
   for (genvar g = 0; g < `ASF_FLAG_W; g++) begin : g_merge
      assign merged[g] = mask[g] ? calc_flags[g] : alu_flags_ff[g];
   end

   // =====================================================
   // flag register and result
   // =====================================================
   logic [7:0]        nxt_flags;
   logic [7:0]        nxt_result;
   logic              nxt_result_we;

   // flag-writing op onto flags: flags only, result not stored
   always_comb begin
      nxt_flags     = alu_flags_ff;
      nxt_result    = result_ff;
      nxt_result_we = 1'b0;
      if (op_valid) begin
         nxt_result = calc;
         if (dest_is_flags && (mask == 5'h00)) begin
            nxt_flags = calc;
         end else begin
            nxt_flags[4:0] = merged;
         end
         nxt_result_we = !dest_is_flags;
      end
      nxt_flags = nxt_flags & `ASF_IMPL_MASK;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         alu_flags_ff <= `ASF_FLAGS_RST;
         result_ff    <= `ASF_RESULT_RST;
         result_we_ff <= 1'b0;
      end else begin
         alu_flags_ff <= nxt_flags;
         result_ff    <= nxt_result;
         result_we_ff <= nxt_result_we;
      end
   end

endmodule
`default_nettype wire

//--- inc/asf_params.svh
/*
   flag unit constants: bit positions, reset values, widths.
   assumes inclusion by bare name from the design.
*/
`ifndef ASF_PARAMS_SVH
`define ASF_PARAMS_SVH
`define ASF_BIT_C      0
`define ASF_BIT_HC     1
`define ASF_BIT_Z      2
`define ASF_BIT_SRF    3
`define ASF_BIT_N      4
`define ASF_FLAG_W     5
`define ASF_FLAGS_RST  8'h00
`define ASF_RESULT_RST 8'h00
`define ASF_GRANT_RST  1'b0
`define ASF_IMPL_MASK  8'h1f
`define ASF_EXT_RST    1'b0
`endif

//--- inc/asf_pkg.sv
/*
   flag unit types: alu operation codes.
   assumes the core decoder drives one code per executed instruction.
*/
`default_nettype none
package asf_pkg;
   typedef enum logic [4:0] {
      asf_op_add, asf_op_addc, asf_op_sub, asf_op_subb,
      asf_op_inc, asf_op_dec, asf_op_neg,
      asf_op_and, asf_op_ior, asf_op_xor, asf_op_com, asf_op_clr,
      asf_op_rlc, asf_op_rrc,
      asf_op_mov, asf_op_swap, asf_op_bset, asf_op_bclr
   } asf_op_t;
endpackage
`default_nettype wire

//--- verification/asf_flag_unit_props.sv
/* checker: flag unit port relations.
   assumes a bind onto asf_flag_unit. */
`timescale 1ns/1ps
`default_nettype none
module asf_flag_props #(
   parameter int DATA_W = 8
) (
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              op_valid,
   input wire asf_pkg::asf_op_t  op_code,
   input wire logic [DATA_W-1:0] opnd_f,
   input wire logic              src_is_flags,
   input wire logic              dest_is_flags,
   input wire logic              idx_req,
   input wire logic [DATA_W-1:0] result_ff,
   input wire logic              result_we_ff,
   input wire logic [DATA_W-1:0] alu_flags_ff,
   input wire logic              ext_isa_enable_ff,
   input wire logic              idx_grant_ff
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   //==========
   // assertions
   AST_UPPER: assert property (alu_flags_ff[7:5] == 3'h0)
      else $error("upper bits set");
   AST_NEG: assert property (
      op_valid && op_code <= asf_pkg::asf_op_com && !dest_is_flags
      |=> alu_flags_ff[4] == result_ff[7]) else $error("negative flag");
   AST_ZERO: assert property (
      op_valid && op_code <= asf_pkg::asf_op_rrc && !dest_is_flags
      |=> alu_flags_ff[2] == (result_ff == '0)) else $error("zero flag");
   AST_WE: assert property (
      1 |=> result_we_ff == ($past(op_valid) && !$past(dest_is_flags)))
      else $error("store strobe");
   AST_KEEP: assert property (
      !op_valid || op_code >= asf_pkg::asf_op_mov && !dest_is_flags
      |=> $stable(alu_flags_ff)) else $error("flags moved");
   AST_CLR: assert property (
      op_valid && op_code == asf_pkg::asf_op_clr
      |=> alu_flags_ff == ($past(alu_flags_ff) | 8'h04)) else $error("clear");
   AST_RLC: assert property (
      op_valid && op_code == asf_pkg::asf_op_rlc && !src_is_flags
      |=> alu_flags_ff[1:0] == {$past(opnd_f[3]), $past(opnd_f[7])})
      else $error("left rotate");
   AST_RRC: assert property (
      op_valid && op_code == asf_pkg::asf_op_rrc && !src_is_flags
      |=> alu_flags_ff[1:0] == {$past(opnd_f[4]), $past(opnd_f[0])})
      else $error("right rotate");
   AST_GRANT: assert property (idx_req && ext_isa_enable_ff |=> idx_grant_ff)
      else $error("no grant");
   AST_NOGRANT: assert property (!(idx_req && ext_isa_enable_ff) |=> !idx_grant_ff)
      else $error("bad grant");
   cover property (op_valid && op_code == asf_pkg::asf_op_clr && dest_is_flags);
   cover property (idx_grant_ff);
   cover property (op_valid && op_code == asf_pkg::asf_op_sub ##1 !alu_flags_ff[0]);
endmodule
`default_nettype wire

//--- verification/asf_flag_unit_bench.sv
/* bench: flag unit against an integer model.
   assumes asf_pkg and the design compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin tests_run++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module asf_flag_unit_bench;
   logic             clk, rst, op_valid, src_is_flags, dest_is_flags;
   logic             ext_isa_pin, idx_req, result_we_ff, ext_isa_enable_ff, idx_grant_ff;
   asf_pkg::asf_op_t op_code;
   logic [7:0]       opnd_w, opnd_f, result_ff, alu_flags_ff;
   logic [2:0]       bit_sel;
   int               fails, tests_run, mf, i;
   asf_flag_unit #(.DATA_W(8)) dut_u (
      .clk               (clk),
      .rst               (rst),
      .op_valid          (op_valid),
      .op_code           (op_code),
      .opnd_w            (opnd_w),
      .opnd_f            (opnd_f),
      .bit_sel           (bit_sel),
      .src_is_flags      (src_is_flags),
      .dest_is_flags     (dest_is_flags),
      .ext_isa_pin       (ext_isa_pin),
      .idx_req           (idx_req),
      .result_ff         (result_ff),
      .result_we_ff      (result_we_ff),
      .alu_flags_ff      (alu_flags_ff),
      .ext_isa_enable_ff (ext_isa_enable_ff),
      .idx_grant_ff      (idx_grant_ff)
   );
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   //==========
   // tasks
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic do_op(int o, int w, int f, bit s, bit d, int b);
      int a, x, y, ci, r, m, nf;
      a = s ? mf : f;
      x = o == 6 ? 0 : a;
      y = o == 4 ? 1 : o == 5 ? 255 : o == 6 ? ~a & 255 : o inside {2, 3} ? ~w & 255 : w;
      ci = o inside {2, 6} ? 1 : o inside {1, 3} ? mf & 1 : 0;
      r = (x + y + ci) & 255;
      nf = (x + y + ci) >> 8 | ((x & 15) + (y & 15) + ci) >> 3 & 2 | ((x ^ r) & (y ^ r) & 128) >> 4;
      case (o)
         7: r = a & w;
         8: r = a | w;
         9: r = a ^ w;
         10: r = ~a & 255;
         11: r = 0;
         12: r = (a << 1 | mf & 1) & 255;
         13: r = (mf & 1) << 7 | a >> 1;
         14: r = w;
         15: r = (a << 4 | a >> 4) & 255;
         16: r = a | 1 << b;
         17: r = a & ~(1 << b) & 255;
         default: ;
      endcase
      if (o == 12) nf = a >> 7 | a >> 2 & 2;
      if (o == 13) nf = a & 1 | a >> 3 & 2;
      nf = nf | r >> 3 & 16 | (r == 0 ? 4 : 0);
      m = o < 7 ? 31 : o < 11 ? 20 : o == 11 ? 4 : o < 14 ? 23 : 0;
      mf = d && m == 0 ? r & 31 : (mf & ~m | nf & m) & 31;
      op_valid = 1;
      op_code = asf_pkg::asf_op_t'(o);
      opnd_w = 8'(w);
      opnd_f = 8'(f);
      bit_sel = 3'(b);
      src_is_flags = s;
      dest_is_flags = d;
      idx_req = 1'($urandom);
      @(posedge clk);
      #1;
      `CHK("store", !d, result_we_ff)
      if (!d) `CHK("result", r, result_ff)
      `CHK("flags", mf, alu_flags_ff)
   endtask
   //==========
   // sequence
   initial begin
      rst = 1;
      {op_valid, src_is_flags, dest_is_flags, ext_isa_pin, idx_req} = '0;
      op_code = asf_pkg::asf_op_add;
      {opnd_w, opnd_f, bit_sel} = '0;
      {mf, fails, tests_run} = '0;
      i = $urandom(32'h906c);
      repeat (16) @(posedge clk);
      #1;
      rst = 0;
      `CHK("reset flags", 0, alu_flags_ff)
      do_op(0, 'h01, 'hff, 0, 0, 0);
      do_op(0, 'h01, 'h7f, 0, 0, 0);
      do_op(1, 'h0f, 'h00, 0, 0, 0);
      do_op(2, 'h05, 'h05, 0, 0, 0);
      do_op(2, 'h01, 'h10, 0, 0, 0);
      do_op(3, 'h00, 'h00, 0, 0, 0);
      do_op(6, 'h00, 'h80, 0, 0, 0);
      do_op(12, 'h00, 'h88, 0, 0, 0);
      do_op(13, 'h00, 'h11, 0, 0, 0);
      do_op(11, 'h00, 'h55, 0, 1, 0);
      do_op(0, 'h00, 'h00, 0, 1, 0);
      do_op(14, 'hff, 'h00, 0, 1, 0);
      do_op(15, 'h00, 'h00, 1, 0, 0);
      do_op(16, 'h00, 'h00, 1, 1, 7);
      $display("test directed done");
      for (i = 0; i < 360; i++)
         do_op(i % 18, $urandom_range(255), $urandom_range(255), $urandom_range(7) == 0,
               $urandom_range(7) == 0, $urandom_range(7));
      op_valid = 0;
      repeat (3) @(posedge clk);
      #1;
      `CHK("idle flags", mf, alu_flags_ff)
      $display("test random done");
      idx_req = 1;
      @(posedge clk);
      #1;
      `CHK("grant off", 0, idx_grant_ff)
      ext_isa_pin = 1;
      repeat (4) @(posedge clk);
      #1;
      `CHK("enable", 1, ext_isa_enable_ff)
      `CHK("grant on", 1, idx_grant_ff)
      rst = 1;
      #5;
      `CHK("rerun flags", 0, alu_flags_ff)
      @(posedge clk);
      #1;
      rst = 0;
      mf = 0;
      do_op(2, 'h01, 'h00, 0, 0, 0);
      op_valid = 0;
      $display("test config done");
      final_report();
   end
   initial begin
      #(2000 * 25);
      fails++;
      final_report();
   end
endmodule
bind asf_flag_unit asf_flag_props #(.DATA_W(DATA_W)) chk_u (
   .clk               (clk),
   .rst               (rst),
   .op_valid          (op_valid),
   .op_code           (op_code),
   .opnd_f            (opnd_f),
   .src_is_flags      (src_is_flags),
   .dest_is_flags     (dest_is_flags),
   .idx_req           (idx_req),
   .result_ff         (result_ff),
   .result_we_ff      (result_we_ff),
   .alu_flags_ff      (alu_flags_ff),
   .ext_isa_enable_ff (ext_isa_enable_ff),
   .idx_grant_ff      (idx_grant_ff)
);
`default_nettype wire
